// File: inc/tcw_pkg.sv
// timer8 waveform package: offsets, fields, modes, reset values
// assumes a plain one-cycle register port and one 125 MHz clock
package tcw_pkg;
  localparam logic [2:0] REG_CTRL_A  = 3'h0;
  localparam logic [2:0] REG_CTRL_B  = 3'h1;
  localparam logic [2:0] REG_COUNT   = 3'h2;
  localparam logic [2:0] REG_CMP_A   = 3'h3;
  localparam logic [2:0] REG_CMP_B   = 3'h4;
  localparam logic [2:0] REG_FLAGS   = 3'h5;
  // ctrl_a: [7:6] action a, [5:4] action b, [1:0] mode low bits
  localparam int ACT_A_POS = 6;
  localparam int ACT_B_POS = 4;
  // ctrl_b: [7] force a, [6] force b, [3] mode high bit, [2:0] clock select
  localparam int FORCE_A_POS = 7;
  localparam int FORCE_B_POS = 6;
  localparam int MODE_HI_POS = 3;
  // flags: [0] overflow, [1] compare a, [2] compare b
  localparam int FLAG_OVF_POS = 0;
  localparam int FLAG_CA_POS  = 1;
  localparam int FLAG_CB_POS  = 2;
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [7:0] COUNT_MAX  = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int PRESCALE_BITS = 10;
endpackage : tcw_pkg

// File: verilog/tcw_timer.sv
// timer8 waveform block: counter, compare channels a and b, pin override
// assumes synchronous register strobes and port bits from the port block
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tcw_timer #(
  parameter int CH = 2
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic [CH-1:0] port_value,
  input  wire logic [CH-1:0] port_dir,
  output logic      [CH-1:0] pin_out,
  output logic      [CH-1:0] pin_oe_n,
  output logic               timer_tick
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]          count_q;
  logic [2:0]          mode_q;
  logic [2:0]          csel_q;
  logic [1:0]          act_q    [CH];
  logic [7:0]          cmp_buf_q[CH];
  logic [7:0]          cmp_act_q[CH];
  logic [CH-1:0]       state_q;
  logic [CH-1:0]       cflag_q;
  logic                ovf_q;
  logic                block_q;
  logic [9:0]          pre_q;
  logic [7:0]          rdata_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_ctrl_a = reg_wr && reg_addr == tcw_pkg::REG_CTRL_A;
  wire wr_ctrl_b = reg_wr && reg_addr == tcw_pkg::REG_CTRL_B;
  wire wr_count  = reg_wr && reg_addr == tcw_pkg::REG_COUNT;
  wire wr_flags  = reg_wr && reg_addr == tcw_pkg::REG_FLAGS;
  wire is_fast   = mode_q == tcw_pkg::MODE_FAST_MAX || mode_q == tcw_pkg::MODE_FAST_CMP;
  wire is_ctc    = mode_q == tcw_pkg::MODE_CLR_MATCH;
  wire [7:0] top = (mode_q == tcw_pkg::MODE_FAST_CMP || is_ctc) ? cmp_act_q[0]
                 : tcw_pkg::COUNT_MAX;
  wire at_top    = count_q == top;
  wire wrap_clr  = (is_fast || is_ctc) && at_top;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // divide select mask
  logic [9:0] pre_mask;
  always_comb begin
    unique case (csel_q)
      3'h1:    pre_mask = 10'h000;
      3'h2:    pre_mask = 10'h007;
      3'h3:    pre_mask = 10'h01F;
      3'h4:    pre_mask = 10'h03F;
      3'h5:    pre_mask = 10'h07F;
      3'h6:    pre_mask = 10'h0FF;
      3'h7:    pre_mask = 10'h3FF;
      default: pre_mask = 10'h000;
    endcase
  end
  wire tick = csel_q != 3'h0 && (pre_q & pre_mask) == 10'h000;
  assign timer_tick = tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 10'h000;
    end else if (csel_q == 3'h0) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  logic [7:0] count_d;
  always_comb begin
    count_d = count_q;
    if (wr_count) begin
      count_d = reg_wdata;
    end else if (tick) begin
      count_d = wrap_clr ? tcw_pkg::RESET_BYTE : count_q + 8'h01;
    end
  end
  wire ovf_evt = tick && !wr_count && (is_fast ? at_top : count_q == tcw_pkg::COUNT_MAX);
  // bottom event for fast pwm reload and output set or clear
  wire bottom_evt = tick && !wr_count && is_fast && at_top;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= tcw_pkg::RESET_BYTE;
      block_q <= 1'b0;
      ovf_q   <= 1'b0;
      mode_q  <= 3'h0;
      csel_q  <= 3'h0;
    end else begin
      count_q <= count_d;
      block_q <= wr_count ? 1'b1 : (tick ? 1'b0 : block_q);
      // flag set wins over clear
      ovf_q   <= ovf_evt | (ovf_q & ~(wr_flags & reg_wdata[tcw_pkg::FLAG_OVF_POS]));
      if (wr_ctrl_a) begin
        mode_q[1:0] <= reg_wdata[1:0];
      end
      if (wr_ctrl_b) begin
        mode_q[2] <= reg_wdata[tcw_pkg::MODE_HI_POS];
        csel_q    <= reg_wdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  logic [CH-1:0] match_evt;
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      wire [2:0] cmp_addr = g == 0 ? tcw_pkg::REG_CMP_A : tcw_pkg::REG_CMP_B;
      wire wr_cmp  = reg_wr && reg_addr == cmp_addr;
      wire [7:0] act_pos = g == 0 ? 8'(tcw_pkg::ACT_A_POS) : 8'(tcw_pkg::ACT_B_POS);
      wire [1:0] act_w  = reg_wdata[act_pos[2:0] +: 2];
      wire fpos    = g == 0 ? reg_wdata[tcw_pkg::FORCE_A_POS] : reg_wdata[tcw_pkg::FORCE_B_POS];
      wire force_s = wr_ctrl_b && fpos && !is_fast;
      wire flag_clr = wr_flags && reg_wdata[tcw_pkg::FLAG_CA_POS + g];
      assign match_evt[g] = tick && !block_q && count_q == cmp_act_q[g];
      logic state_d;
      always_comb begin
        state_d = state_q[g];
        // zero wins over match so max holds constant
        if (bottom_evt && act_q[g] == tcw_pkg::ACT_CLEAR) begin
          state_d = 1'b1;
        end else if (bottom_evt && act_q[g] == tcw_pkg::ACT_SET) begin
          state_d = 1'b0;
        end else if (match_evt[g] || force_s) begin
          unique case (act_q[g])
            tcw_pkg::ACT_TOGGLE: state_d = ~state_q[g];
            tcw_pkg::ACT_CLEAR:  state_d = 1'b0;
            tcw_pkg::ACT_SET:    state_d = 1'b1;
            default:             state_d = state_q[g];
          endcase
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          act_q[g]     <= tcw_pkg::ACT_NONE;
          cmp_buf_q[g] <= tcw_pkg::RESET_BYTE;
          cmp_act_q[g] <= tcw_pkg::RESET_BYTE;
          state_q[g]   <= 1'b0;
          cflag_q[g]   <= 1'b0;
        end else begin
          // new action acts at next match
          if (wr_ctrl_a) begin
            act_q[g] <= act_w;
          end
          if (wr_cmp) begin
            cmp_buf_q[g] <= reg_wdata;
          end
          // direct outside pwm, reload at bottom in pwm
          if (!is_fast) begin
            cmp_act_q[g] <= wr_cmp ? reg_wdata : cmp_buf_q[g];
          end else if (bottom_evt) begin
            cmp_act_q[g] <= cmp_buf_q[g];
          end
          state_q[g] <= state_d;
          cflag_q[g] <= match_evt[g] | (cflag_q[g] & ~flag_clr);
        end
      end
      assign pin_out[g]  = act_q[g] != tcw_pkg::ACT_NONE ? state_q[g] : port_value[g];
      assign pin_oe_n[g] = ~port_dir[g];
    end
  endgenerate

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      tcw_pkg::REG_CTRL_A: rd_mux = {act_q[0], act_q[1], 2'h0, mode_q[1:0]};
      tcw_pkg::REG_CTRL_B: rd_mux = {4'h0, mode_q[2], csel_q};
      tcw_pkg::REG_COUNT:  rd_mux = count_q;
      tcw_pkg::REG_CMP_A:  rd_mux = cmp_buf_q[0];
      tcw_pkg::REG_CMP_B:  rd_mux = cmp_buf_q[1];
      tcw_pkg::REG_FLAGS:  rd_mux = {5'h00, cflag_q[1:0], ovf_q};
      default:             rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_wrap_normal;
    tick && !wr_count && mode_q == 3'h0 && count_q == 8'hFF |=> count_q == 8'h00;
  endproperty
  a_wrap_normal: assert property (p_wrap_normal) else $error("normal wrap wrong");

  property p_ovf_set;
    ovf_evt |=> ovf_q && count_q == 8'h00;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_ctc_clear;
    tick && !wr_count && is_ctc && count_q == cmp_act_q[0] |=> count_q == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missed");

  property p_flag_a;
    match_evt[0] |=> cflag_q[0];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("compare flag a not set");

  logic wr_pend_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_count || (wr_pend_q && !tick);
    end
  end

  sequence s_cnt_wr;
    wr_pend_q && tick;
  endsequence
  property p_block;
    s_cnt_wr |-> match_evt == '0;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_stop;
    csel_q == 3'h0 && !wr_count |=> count_q == $past(count_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");

  property p_pin;
    act_q[0] != 2'h0 |-> pin_out[0] == state_q[0] && pin_oe_n[0] == ~port_dir[0];
  endproperty
  a_pin: assert property (p_pin) else $error("pin override wrong");

  property p_act_none;
    act_q[0] == 2'h0 |=> state_q[0] == $past(state_q[0]);
  endproperty
  a_act_none: assert property (p_act_none) else $error("state moved with no action");

  property p_fast_set;
    bottom_evt && act_q[0] == 2'h2 |=> state_q[0] && count_q == 8'h00;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("pwm set at zero missed");

  property p_tick8;
    csel_q == 3'h2 && $stable(csel_q) && tick |=> !tick [*7];
  endproperty
  a_tick8: assert property (p_tick8) else $error("divide by 8 wrong");

  property p_pin_port;
    act_q[0] == 2'h0 |-> pin_out[0] == port_value[0];
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("port value not on pin");

  property p_oe;
    pin_oe_n == ~port_dir;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");

  property p_norm_inc;
    tick && !wr_count && mode_q == 3'h0 |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_norm_inc: assert property (p_norm_inc) else $error("normal count wrong");

  property p_wr_wins;
    wr_count |=> count_q == $past(reg_wdata);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("counter write lost");

  property p_ctc_wrap;
    tick && !wr_count && is_ctc && count_q == 8'hFF |=> count_q == 8'h00 && ovf_q;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc wrap wrong");

  property p_direct;
    !is_fast |=> cmp_act_q[0] == cmp_buf_q[0];
  endproperty
  a_direct: assert property (p_direct) else $error("compare not direct");

  property p_ctc_flag;
    tick && !block_q && is_ctc && count_q == cmp_act_q[0] |=> cflag_q[0];
  endproperty
  a_ctc_flag: assert property (p_ctc_flag) else $error("ctc flag missed");

  property p_ctc_toggle;
    match_evt[0] && is_ctc && act_q[0] == 2'h1 |=> state_q[0] != $past(state_q[0]);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("ctc toggle missed");

  property p_top_max;
    tick && !wr_count && mode_q == 3'h3 && count_q == 8'hFF |=> count_q == 8'h00;
  endproperty
  a_top_max: assert property (p_top_max) else $error("fast max top wrong");

  property p_top_cmp;
    tick && !wr_count && mode_q == 3'h7 && count_q == cmp_act_q[0] |=> count_q == 8'h00;
  endproperty
  a_top_cmp: assert property (p_top_cmp) else $error("fast compare top wrong");

  property p_fast_inc;
    tick && !wr_count && is_fast && !at_top |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_fast_inc: assert property (p_fast_inc) else $error("fast count wrong");

  property p_fast_clr;
    match_evt[0] && is_fast && act_q[0] == 2'h2 && !bottom_evt |=> !state_q[0];
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("pwm clear on match missed");

  property p_fast_inv;
    bottom_evt && act_q[0] == 2'h3 |=> !state_q[0];
  endproperty
  a_fast_inv: assert property (p_fast_inv) else $error("pwm clear at zero missed");

  property p_fast_ovf;
    bottom_evt |=> ovf_q;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("pwm overflow missed");

  property p_hold_buf;
    is_fast && !bottom_evt |=> $stable(cmp_act_q[0]);
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("pwm compare not held");

  property p_reload;
    bottom_evt |=> cmp_act_q[0] == $past(cmp_buf_q[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("pwm reload missed");

  property p_fast_toggle;
    match_evt[0] && is_fast && act_q[0] == 2'h1 |=> state_q[0] != $past(state_q[0]);
  endproperty
  a_fast_toggle: assert property (p_fast_toggle) else $error("pwm toggle missed");

  property p_force;
    wr_ctrl_b && reg_wdata[tcw_pkg::FORCE_A_POS] && !is_fast && act_q[0] == 2'h3 |=> state_q[0];
  endproperty
  a_force: assert property (p_force) else $error("force strobe ignored");

  property p_tick1;
    csel_q == 3'h1 |-> tick;
  endproperty
  a_tick1: assert property (p_tick1) else $error("divide by 1 wrong");

  property p_stop_tick;
    csel_q == 3'h0 |-> !tick;
  endproperty
  a_stop_tick: assert property (p_stop_tick) else $error("tick while stopped");
endmodule : tcw_timer

// File: sim/tb.sv
// testbench for the timer8 waveform block: registers, counting modes, pin override
// assumes the register port and bit layout of tcw_pkg and one 125 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] port_value = 2'h0;
  logic [1:0] port_dir = 2'h0;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic       timer_tick;
  logic [7:0] d;
  int         checks = 0;
  int         n_fail = 0;

  always #4 clk = ~clk;

  tcw_timer #(.CH(2)) u_tcw_timer (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_value(port_value), .port_dir(port_dir), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .timer_tick(timer_tick)
  );

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // runs the timer for exactly n ticks at full rate, then stops it
  task automatic step(input int n);
    wr(tcw_pkg::REG_CTRL_B, 8'h01);
    repeat (n - 2) @(posedge clk);
    wr(tcw_pkg::REG_CTRL_B, 8'h00);
    #1;
  endtask : step

  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      `CHK(d, 8'h00)
    end
  endtask : t_reset

  task automatic t_pin;
    @(posedge clk);
    port_value <= 2'h2;
    port_dir <= 2'h1;
    @(posedge clk);
    #1 `CHK(pin_out, 2'h2)
    `CHK(pin_oe_n, 2'h2)
    wr(tcw_pkg::REG_CTRL_A, 8'hC0);
    wr(tcw_pkg::REG_CTRL_B, 8'h80);
    #1 `CHK(pin_out, 2'h3)
    wr(tcw_pkg::REG_CTRL_A, 8'h80);
    wr(tcw_pkg::REG_CTRL_B, 8'h80);
    #1 `CHK(pin_out, 2'h2)
    @(posedge clk);
    port_value <= 2'h1;
    wr(tcw_pkg::REG_CTRL_A, 8'h82);
    #1 `CHK(pin_out, 2'h0)
    wr(tcw_pkg::REG_CTRL_A, 8'h30);
    wr(tcw_pkg::REG_CTRL_B, 8'h40);
    #1 `CHK(pin_out, 2'h3)
  endtask : t_pin

  task automatic t_normal;
    wr(tcw_pkg::REG_CTRL_A, 8'h00);
    wr(tcw_pkg::REG_CMP_A, 8'h80);
    wr(tcw_pkg::REG_CMP_B, 8'h80);
    wr(tcw_pkg::REG_COUNT, 8'hFE);
    wr(tcw_pkg::REG_FLAGS, 8'h07);
    step(2);
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h00)
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d[0], 1'b1)
    wr(tcw_pkg::REG_FLAGS, 8'h01);
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d, 8'h00)
    wr(tcw_pkg::REG_CMP_A, 8'h20);
    wr(tcw_pkg::REG_COUNT, 8'h20);
    step(2);
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d[1], 1'b0)
    wr(tcw_pkg::REG_COUNT, 8'h1F);
    step(2);
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d[1], 1'b1)
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h21)
  endtask : t_normal

  task automatic t_ctc;
    wr(tcw_pkg::REG_CTRL_A, 8'h42);
    wr(tcw_pkg::REG_CMP_A, 8'h03);
    wr(tcw_pkg::REG_COUNT, 8'h00);
    wr(tcw_pkg::REG_FLAGS, 8'h07);
    step(4);
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h00)
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d[1], 1'b1)
    `CHK(pin_out[0], 1'b1)
    step(4);
    `CHK(pin_out[0], 1'b0)
    wr(tcw_pkg::REG_COUNT, 8'h05);
    step(4);
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h09)
  endtask : t_ctc

  task automatic t_fast;
    wr(tcw_pkg::REG_CTRL_A, 8'h83);
    wr(tcw_pkg::REG_CMP_A, 8'h10);
    wr(tcw_pkg::REG_COUNT, 8'hFE);
    wr(tcw_pkg::REG_FLAGS, 8'h07);
    step(2);
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h00)
    rd(tcw_pkg::REG_FLAGS);
    `CHK(d[0], 1'b1)
    `CHK(pin_out[0], 1'b1)
    wr(tcw_pkg::REG_CMP_A, 8'h08);
    step(9);
    `CHK(pin_out[0], 1'b1)
    step(8);
    `CHK(pin_out[0], 1'b0)
    rd(tcw_pkg::REG_COUNT);
    `CHK(d, 8'h11)
  endtask : t_fast

  task automatic t_presc;
    int div [7];
    int cnt;
    div = '{1, 8, 32, 64, 128, 256, 1024};
    for (int i = 0; i < 7; i++) begin
      wr(tcw_pkg::REG_CTRL_B, 8'(i + 1));
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (2 * div[i]) begin
        @(posedge clk);
        #1 if (timer_tick === 1'b1) cnt++;
      end
      `CHK(cnt, 2)
    end
    wr(tcw_pkg::REG_CTRL_B, 8'h00);
    cnt = 0;
    repeat (32) begin
      @(posedge clk);
      #1 if (timer_tick !== 1'b0) cnt++;
    end
    `CHK(cnt, 0)
  endtask : t_presc

  task automatic t_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CHK(pin_out, port_value)
    t_reset();
  endtask : t_rst

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pin();
    t_normal();
    t_ctc();
    t_fast();
    t_rst();
    t_presc();
    finish_test();
  end

  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tb
